/* File: logic/sdram_memory_interface.sv */
// sdram pin-level command, address, mask, data and clock interface
`timescale 1ns/100ps
`include "sdram_if_defs.svh"

module sdram_memory_interface
  import sdram_if_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          reset_n_i,
  input  wire mem_req_t      req_i,
  input  wire logic          sleep_req_i,
  input  wire logic [63:0]   memory_data_bus_i,
  input  wire logic          read_capture_clock_in_i,
  output logic [63:0]        memory_data_bus_o,
  output logic               memory_data_bus_oe_o,
  output logic [12:0]        memory_row_col_address_o,
  output logic [1:0]         bank_address_o,
  output logic [1:0]         chip_select_n_o,
  output logic               row_strobe_out_n_o,
  output logic               column_strobe_out_n_o,
  output logic               write_enable_out_n_o,
  output logic               memory_clock_enable_out_o,
  output logic [7:0]         data_mask_o,
  output logic [3:0]         memory_clock_out_o,
  output logic               read_capture_clock_out_o,
  output logic [63:0]        rdata_o,
  output logic               rdata_valid_o,
  output logic               asleep_o
);

  ctrl_state_t s_q;
  ctrl_state_t s_d;

  function automatic mem_cmd_pins_t encode(input logic [3:0] c, input logic sel,
                                           input logic cke);
    mem_cmd_pins_t p;
    p.chip_sel_n      = sel ? 2'h1 : 2'h2;
    p.row_strobe_n    = c[2];
    p.column_strobe_n = c[1];
    p.write_enable_n  = c[0];
    p.clock_enable    = cke;
    return p;
  endfunction

  always_comb begin
    logic [3:0] code;
    logic       idle;
    code = `CMD_NOP;
    // no power-down while read data is still due or write data is on the bus
    idle = (s_q.rd_pipe == 3'h0) && !s_q.dout_en;
    s_d = s_q;
    s_d.rdata_valid = 1'b0;
    s_d.dout_en = 1'b0;
    s_d.cmd = '{chip_sel_n: `CS_NONE, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                write_enable_n: 1'b1, clock_enable: s_q.cmd.clock_enable};
    // memory clock divided from the system clock; 3,1 and 2,0 stay paired
    s_d.clk_cnt = s_q.clk_cnt + 4'h1;
    if (s_q.clk_cnt == `MEM_CLK_DIV - 4'h1) begin
      s_d.clk_cnt = 4'h0;
      s_d.mem_clk = ~s_q.mem_clk;
    end
    // memory clocks of a sleeping module stop two cycles after its clock enable falls
    s_d.mem_clk_out = s_q.asleep ? 4'h0 : {4{s_d.mem_clk}};
    s_d.capture_clk_out = s_d.mem_clk;
    s_d.rd_pipe = {s_q.rd_pipe[1:0], 1'b0};
    case (s_q.pwr)
      ST_ACTIVE: begin
        s_d.dqm = `DQM_NONE;
        if (sleep_req_i && idle && !req_i.valid) begin
          // self-refresh keeps contents valid while clock enable is low
          s_d.cmd = encode(`CMD_SELF_REFRESH, 1'b0, 1'b0);
          s_d.cmd.chip_sel_n = 2'h0;
          s_d.pwr = ST_ENTER_SLEEP;
        end else if (req_i.valid) begin
          case (req_i.op)
            OP_ACTIVATE:  code = `CMD_ACTIVATE;
            OP_READ:      code = `CMD_READ;
            OP_WRITE:     code = `CMD_WRITE;
            OP_PRECHARGE: code = `CMD_PRECHARGE;
            OP_REFRESH:   code = `CMD_REFRESH;
            OP_MODE_SET:  code = `CMD_MODE_SET;
            default:      code = `CMD_NOP;
          endcase
          s_d.cmd = encode(code, req_i.module_sel, 1'b1);
          s_d.addr = req_i.addr;
          s_d.bank = req_i.bank;
          if (req_i.op == OP_READ) begin
            s_d.dqm = `DQM_ALL;
            s_d.rd_pipe[0] = 1'b1;
          end
          if (req_i.op == OP_WRITE) begin
            s_d.dqm = ~req_i.byte_en;
            s_d.dout = req_i.wdata;
            s_d.dout_en = 1'b1;
          end
        end
      end
      ST_ENTER_SLEEP: begin
        s_d.asleep = 1'b1;
        s_d.pwr = ST_ASLEEP;
      end
      ST_ASLEEP: begin
        if (!sleep_req_i) begin
          s_d.cmd.clock_enable = 1'b1;
          s_d.asleep = 1'b0;
          s_d.pwr = ST_ACTIVE;
        end
      end
      default: s_d.pwr = ST_ACTIVE;
    endcase
    // capture clock is synchronised; data sampled on its rising edge
    s_d.cap_s1 = read_capture_clock_in_i;
    s_d.cap_s2 = s_q.cap_s1;
    s_d.cap_s3 = s_q.cap_s2;
    if (s_q.cap_s2 && !s_q.cap_s3 && (s_q.rd_pipe[2] || s_q.rd_pipe[1])) begin
      s_d.rdata = memory_data_bus_i;
      s_d.rdata_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
      s_q.cmd <= '{chip_sel_n: `CS_NONE, row_strobe_n: 1'b1, column_strobe_n: 1'b1,
                   write_enable_n: 1'b1, clock_enable: 1'b1};
      s_q.pwr <= ST_ACTIVE;
    end else begin
      s_q <= s_d;
    end
  end

  assign memory_data_bus_o         = s_q.dout;
  assign memory_data_bus_oe_o      = s_q.dout_en;
  assign memory_row_col_address_o  = s_q.addr;
  assign bank_address_o            = s_q.bank;
  assign chip_select_n_o           = s_q.cmd.chip_sel_n;
  assign row_strobe_out_n_o        = s_q.cmd.row_strobe_n;
  assign column_strobe_out_n_o     = s_q.cmd.column_strobe_n;
  assign write_enable_out_n_o      = s_q.cmd.write_enable_n;
  assign memory_clock_enable_out_o = s_q.cmd.clock_enable;
  assign data_mask_o               = s_q.dqm;
  assign memory_clock_out_o        = s_q.mem_clk_out;
  assign read_capture_clock_out_o  = s_q.capture_clk_out;
  assign rdata_o                   = s_q.rdata;
  assign rdata_valid_o             = s_q.rdata_valid;
  assign asleep_o                  = s_q.asleep;

  logic idle_now;
  assign idle_now = (s_q.rd_pipe == 3'h0) && !s_q.dout_en;

  sequence seq_sleep_entry;
    s_q.pwr == ST_ACTIVE && sleep_req_i && !req_i.valid && idle_now;
  endsequence

  sequence seq_wake;
    s_q.pwr == ST_ASLEEP && !sleep_req_i;
  endsequence

  chk_read_mask_all: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ACTIVE && req_i.valid && req_i.op == OP_READ && !sleep_req_i
      |=> data_mask_o == 8'hFF && !memory_data_bus_oe_o)
    else $error("read masks not all asserted");
  chk_write_mask: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ACTIVE && req_i.valid && req_i.op == OP_WRITE && !sleep_req_i
      |=> data_mask_o == ~$past(req_i.byte_en) && memory_data_bus_oe_o)
    else $error("write mask does not follow byte enables");
  chk_one_select: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    memory_clock_enable_out_o && !row_strobe_out_n_o |-> chip_select_n_o != 2'h0)
    else $error("both chip selects active for a command");
  chk_sleep_entry: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_sleep_entry |=> !memory_clock_enable_out_o && !row_strobe_out_n_o
      && !column_strobe_out_n_o && write_enable_out_n_o ##1 asleep_o)
    else $error("self-refresh entry not encoded");
  chk_cke_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    $fell(memory_clock_enable_out_o) |-> $past(idle_now))
    else $error("clock enable dropped during a transfer");
  chk_wake: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    seq_wake |=> memory_clock_enable_out_o && !asleep_o)
    else $error("clock enable not raised on wake");
  chk_clk_pairs: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    memory_clock_out_o[3] == memory_clock_out_o[1]
      && memory_clock_out_o[2] == memory_clock_out_o[0])
    else $error("memory clock pairs differ");
  chk_activate_code: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ACTIVE && req_i.valid && req_i.op == OP_ACTIVATE && !sleep_req_i
      |=> !row_strobe_out_n_o && column_strobe_out_n_o && write_enable_out_n_o
        && memory_row_col_address_o == $past(req_i.addr))
    else $error("activate command miscoded");
  // a module bank whose clocks keep running cannot hold its suspend state
  chk_clocks_parked: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    asleep_o && $past(asleep_o) |-> memory_clock_out_o == 4'h0)
    else $error("memory clocks run during self-refresh");
  chk_asleep_refuse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ASLEEP && sleep_req_i |=> chip_select_n_o == 2'h3 && !memory_data_bus_oe_o)
    else $error("command issued during self-refresh");
  chk_write_select: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ACTIVE && req_i.valid && req_i.op == OP_WRITE
      |=> chip_select_n_o == ($past(req_i.module_sel) ? 2'h1 : 2'h2))
    else $error("write sent to the wrong module bank");
  chk_bank_follow: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    s_q.pwr == ST_ACTIVE && req_i.valid |=> bank_address_o == $past(req_i.bank))
    else $error("bank address does not follow the request");
  // rdata_o holds until the next capture, so only the pulse edge is checked
  chk_read_capture: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    rdata_valid_o |-> rdata_o == $past(memory_data_bus_i))
    else $error("captured read data differs from the bus");
endmodule

/* File: shared/sdram_if_defs.svh */
// timing counts, encodings and reset values for the sdram pin interface
`ifndef SDRAM_IF_DEFS_SVH
`define SDRAM_IF_DEFS_SVH
`define CLK_PERIOD_NS     40
`define MEM_CLK_DIV       4'h2
`define CMD_NOP           4'h7
`define CMD_ACTIVATE      4'h3
`define CMD_READ          4'h5
`define CMD_WRITE         4'h4
`define CMD_PRECHARGE     4'h2
`define CMD_REFRESH       4'h1
`define CMD_SELF_REFRESH  4'h1
`define CMD_MODE_SET      4'h0
`define CS_NONE           2'h3
`define DQM_ALL           8'hFF
`define DQM_NONE          8'h00
`define READ_LATENCY      3'h2
`endif

/* File: shared/sdram_if_pkg.sv */
// types for the sdram pin interface
package sdram_if_pkg;
  typedef enum logic [2:0] {
    OP_NOP, OP_ACTIVATE, OP_READ, OP_WRITE, OP_PRECHARGE, OP_REFRESH, OP_MODE_SET
  } mem_op_t;

  typedef struct packed {
    logic          valid;
    mem_op_t       op;
    logic          module_sel;
    logic [1:0]    bank;
    logic [12:0]   addr;
    logic [63:0]   wdata;
    logic [7:0]    byte_en;
  } mem_req_t;

  typedef struct packed {
    logic [1:0]    chip_sel_n;
    logic          row_strobe_n;
    logic          column_strobe_n;
    logic          write_enable_n;
    logic          clock_enable;
  } mem_cmd_pins_t;

  typedef enum logic [1:0] {ST_ACTIVE, ST_ENTER_SLEEP, ST_ASLEEP} pwr_state_t;

  typedef struct packed {
    pwr_state_t    pwr;
    mem_cmd_pins_t cmd;
    logic [12:0]   addr;
    logic [1:0]    bank;
    logic [7:0]    dqm;
    logic [63:0]   dout;
    logic          dout_en;
    logic [3:0]    clk_cnt;
    logic          mem_clk;
    logic [3:0]    mem_clk_out;
    logic          capture_clk_out;
    logic [2:0]    rd_pipe;
    logic          cap_s1;
    logic          cap_s2;
    logic          cap_s3;
    logic [63:0]   rdata;
    logic          rdata_valid;
    logic          asleep;
  } ctrl_state_t;
endpackage

/* File: tb/mem_partner_model.sv */
// behavioural sdram module: read data and free-running capture clock
`timescale 1ns/100ps
module mem_partner_model #(
  parameter logic [63:0] READ_WORD = 64'h0123_4567_89AB_CDEF
) (
  input  wire logic        clk_sys_i,
  input  wire logic [1:0]  chip_select_n_i,
  input  wire logic        row_strobe_out_n_i,
  input  wire logic        column_strobe_out_n_i,
  input  wire logic        write_enable_out_n_i,
  output logic [63:0]      memory_data_bus_o,
  output logic             read_capture_clock_o
);
  int hold_cnt = 0;
  logic rd_seen;
  assign rd_seen = chip_select_n_i != 2'h3 && row_strobe_out_n_i && !column_strobe_out_n_i
                   && write_enable_out_n_i;
  initial read_capture_clock_o = 1'b0;
  initial memory_data_bus_o = ~READ_WORD;
  // free running, period of eight clk_sys_i cycles, edges on falling edges of clk_sys_i
  always #160 read_capture_clock_o = ~read_capture_clock_o;
  always @(posedge clk_sys_i) begin
    if (rd_seen) begin
      hold_cnt <= 10;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  // released bus toggles between READ_WORD and its inverse, so it never holds one value
  always @(posedge clk_sys_i) begin
    // data from the edge that sees the read, so it stands through the whole capture window
    memory_data_bus_o <= (rd_seen || hold_cnt > 0) ? READ_WORD : ~memory_data_bus_o;
  end
endmodule

/* File: tb/sdram_memory_interface_tb.sv */
// self-checking bench for the sdram pin interface
`timescale 1ns/100ps
`include "sdram_if_defs.svh"
module sdram_memory_interface_tb;
  import sdram_if_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  mem_req_t    req_i = '0;
  logic        sleep_req_i = 1'b0;
  logic [63:0] rd_bus, wr_bus, rdata;
  logic        cap_clk, cap_out, oe, ras_n, cas_n, we_n, cke, rvalid, asleep;
  logic [12:0] addr;
  logic [1:0]  ba, cs_n;
  logic [7:0]  dqm;
  logic [3:0]  mclk;
  int          n_fail = 0;
  int          n_tests = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  sdram_memory_interface dut_u (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i),
    .sleep_req_i(sleep_req_i), .memory_data_bus_i(rd_bus), .read_capture_clock_in_i(cap_clk),
    .memory_data_bus_o(wr_bus), .memory_data_bus_oe_o(oe), .memory_row_col_address_o(addr),
    .bank_address_o(ba), .chip_select_n_o(cs_n), .row_strobe_out_n_o(ras_n),
    .column_strobe_out_n_o(cas_n), .write_enable_out_n_o(we_n),
    .memory_clock_enable_out_o(cke), .data_mask_o(dqm), .memory_clock_out_o(mclk),
    .read_capture_clock_out_o(cap_out), .rdata_o(rdata), .rdata_valid_o(rvalid),
    .asleep_o(asleep));
  mem_partner_model model_u (.clk_sys_i(clk_sys_i), .chip_select_n_i(cs_n),
    .row_strobe_out_n_i(ras_n), .column_strobe_out_n_i(cas_n), .write_enable_out_n_i(we_n),
    .memory_data_bus_o(rd_bus), .read_capture_clock_o(cap_clk));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // request is held across exactly one sampling edge
  task automatic issue(input mem_op_t op, input logic sel, input logic [7:0] be);
    @(negedge clk_sys_i);
    req_i = '{1'b1, op, sel, 2'h2, 13'h1A5C, 64'hFEDC_BA98_7654_3210, be};
    @(negedge clk_sys_i);
    req_i.valid = 1'b0;
  endtask
  task automatic test_write();
    for (int s = 0; s < 2; s++) begin
      issue(OP_WRITE, s[0], 8'hA5 ^ s[7:0]);
      check("cs_n", cs_n, s ? 2'h1 : 2'h2);
      check("cmd", {ras_n, cas_n, we_n}, `CMD_WRITE);
      check("dqm", dqm, 8'(~(8'hA5 ^ s[7:0])));
      check("wdata", oe ? wr_bus : 64'h0, 64'hFEDC_BA98_7654_3210);
      check("addr", {ba, addr}, {2'h2, 13'h1A5C});
      @(negedge clk_sys_i);
      check("oe off", {oe, cs_n}, {1'b0, 2'h3});
    end
  endtask
  task automatic test_cmds();
    mem_op_t ops [4] = '{OP_ACTIVATE, OP_PRECHARGE, OP_REFRESH, OP_MODE_SET};
    logic [3:0] codes [4] = '{`CMD_ACTIVATE, `CMD_PRECHARGE, `CMD_REFRESH, `CMD_MODE_SET};
    for (int i = 0; i < 4; i++) begin
      issue(ops[i], 1'b0, 8'h00);
      check("cmd", {ras_n, cas_n, we_n, dqm}, {codes[i][2:0], `DQM_NONE});
    end
  endtask
  task automatic test_clocks();
    logic prev_cap;
    logic prev_mclk;
    int   n_cap = 0;
    int   n_mclk = 0;
    @(negedge clk_sys_i);
    prev_cap = cap_out;
    prev_mclk = mclk[0];
    repeat (8) begin
      @(negedge clk_sys_i);
      if (cap_out !== prev_cap) n_cap++;
      if (mclk[0] !== prev_mclk) n_mclk++;
      prev_cap = cap_out;
      prev_mclk = mclk[0];
      check("mclk pairs", {mclk[3], mclk[2]}, {mclk[1], mclk[0]});
    end
    check("mclk toggles", 64'(n_mclk), 64'(8 / `MEM_CLK_DIV));
    check("capclk toggles", 64'(n_cap), 64'(8 / `MEM_CLK_DIV));
  endtask
  task automatic test_read();
    int got = 0;
    // the capture window can miss the slow clock, so the phase is walked
    for (int i = 0; i < 9 && got == 0; i++) begin
      issue(OP_READ, 1'b1, 8'h00);
      check("rd dqm", {cs_n, ras_n, cas_n, we_n, dqm}, {2'h1, 3'h5, `DQM_ALL});
      for (int k = 0; k < 7 && got == 0; k++) begin
        @(negedge clk_sys_i);
        if (rvalid === 1'b1) got = 1;
      end
    end
    check("captured", got, 1);
    check("rdata", rdata, 64'h0123_4567_89AB_CDEF);
  endtask
  task automatic test_sleep();
    @(negedge clk_sys_i);
    sleep_req_i = 1'b1;
    @(negedge clk_sys_i);
    check("enter", {cke, cs_n, ras_n, cas_n, we_n},
          {1'b0, 2'h0, 3'(`CMD_SELF_REFRESH)});
    issue(OP_WRITE, 1'b0, 8'hFF);
    check("asleep", {asleep, cke, cs_n, oe}, {2'h2, 2'h3, 1'b0});
    repeat (4) begin
      @(negedge clk_sys_i);
      check("mclk", mclk, 4'h0);
    end
    sleep_req_i = 1'b0;
    @(negedge clk_sys_i);
    check("wake", {cke, asleep}, 2'h2);
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (8) @(negedge clk_sys_i);
    check("rst", {cs_n, cke, dqm, oe, mclk}, {2'h3, 1'b1, 8'h00, 1'b0, 4'h0});
    reset_n_i = 1'b1;
    test_clocks();
    test_write();
    test_cmds();
    test_read();
    test_sleep();
    stop_test();
  end
endmodule
